// ---- rtl/pps_top.sv ----
// Start-up and shut-down sequencer of the projector controller
// Function
// [RQ1] Enable high powers up; low starts park
// [RQ2] Other holds reset 5 ms, park high
// [RQ3] Reset rising edge starts auto initialization
// [RQ4] Drive status flag low when init done
// [RQ5] Host waits for flag low before I2C
// [RQ6] Host stops I2C before dropping enable
// [RQ7] Normal park completes within 20 ms
// [RQ8] Other keeps clock 20 ms after enable
// [RQ9] In reset release status flag line
// [RQ10] Park request low starts fast park
// [RQ11] Other keeps clock 32 us after request
// [RQ12] Init locks PLL then loads flash config
// [RQ13] Drive status flag high during init
// [RQ14] Other keeps enable until flag low
// [RQ15] Other holds reset off 32 us after
// [RQ16] Fast park has priority, then wait
`timescale 1ns/1ps
`default_nettype none
`include "pps_cfg.svh"
module pps_top (
    input  wire logic                    i_clk,
    input  wire logic                    i_rstn,
    input  wire logic                    i_projector_enable,
    input  wire logic                    i_fast_park_request_n,
    input  wire logic                    i_pll_locked,
    input  wire logic                    i_flash_valid,
    input  wire logic [7:0]              i_flash_data,
    output logic                         o_flash_req,
    output logic      [`PPS_CFG_AW-1:0]  o_flash_addr,
    output logic                         o_host_status_flag_o,
    output logic                         o_host_status_flag_oe,
    output logic                         o_host_cmd_allow,
    output logic                         o_display_enable,
    output logic                         o_mirror_park_req,
    output logic                         o_mirror_fast_park,
    output logic                         o_parked,
    output logic      [7:0]              o_cfg_word0
);
    import pps_pkg::*;

    pps_state_t                state_reg;
    pps_state_t                state_next;
    logic [`PPS_CNT_W-1:0]     cnt_reg;
    logic [`PPS_CFG_AW-1:0]    addr_reg;
    logic                      en_s1_reg, en_s2_reg, en_d_reg;
    logic                      pk_s1_reg, pk_s2_reg;
    logic                      pll_s1_reg, pll_s2_reg;
    logic                      cfg_last;
    logic                      en_fall;
    logic [7:0]                rd_data;

    // Enable, park request and lock inputs cross into the clock domain through two flops
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            en_s1_reg  <= 1'b0;
            en_s2_reg  <= 1'b0;
            en_d_reg   <= 1'b0;
            pk_s1_reg  <= 1'b1;
            pk_s2_reg  <= 1'b1;
            pll_s1_reg <= 1'b0;
            pll_s2_reg <= 1'b0;
        end else begin
            en_s1_reg  <= i_projector_enable;
            en_s2_reg  <= en_s1_reg;
            en_d_reg   <= en_s2_reg;
            pk_s1_reg  <= i_fast_park_request_n;
            pk_s2_reg  <= pk_s1_reg;
            pll_s1_reg <= i_pll_locked;
            pll_s2_reg <= pll_s1_reg;
        end
    end

    assign en_fall  = en_d_reg & ~en_s2_reg;
    assign cfg_last = (addr_reg == `PPS_CFG_AW'(`PPS_CFG_WORDS - 1));

    // Next state; fast park overrides every live state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PPS_RESET:
                state_next = PPS_PLL_LOCK; // [RQ3]
            PPS_PLL_LOCK:
                if (pll_s2_reg) begin
                    state_next = PPS_CFG_LOAD; // [RQ12]
                end
            PPS_CFG_LOAD:
                if (i_flash_valid && cfg_last) begin
                    state_next = PPS_ACTIVE; // [RQ12]
                end
            PPS_ACTIVE:
                if (en_fall) begin
                    state_next = PPS_NORMAL_PARK; // [RQ1]
                end
            PPS_NORMAL_PARK:
                if (cnt_reg == '0) begin
                    state_next = PPS_PARKED; // [RQ7]
                end
            PPS_FAST_PARK:
                if (cnt_reg == '0) begin
                    state_next = PPS_PARKED;
                end
            PPS_PARKED:
                state_next = PPS_PARKED;
        endcase
        if (!pk_s2_reg && state_reg != PPS_FAST_PARK
                && state_reg != PPS_PARKED) begin
            state_next = PPS_FAST_PARK; // [RQ10] [RQ16]
        end
    end

    // State register; reset is the only way out of parked
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= PPS_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Park timer loads on entry so park ends inside its bound
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= '0;
        end else if (state_next == PPS_NORMAL_PARK
                     && state_reg != PPS_NORMAL_PARK) begin
            cnt_reg <= `PPS_CNT_W'(`PPS_NPARK_CYC); // [RQ7]
        end else if (state_next == PPS_FAST_PARK
                     && state_reg != PPS_FAST_PARK) begin
            cnt_reg <= `PPS_CNT_W'(`PPS_FPARK_CYC); // [RQ10]
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Flash word address walks the configuration image in order
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            addr_reg <= '0;
        end else if (state_reg == PPS_CFG_LOAD && i_flash_valid
                     && !cfg_last) begin
            addr_reg <= addr_reg + 1'b1; // [RQ12]
        end
    end

    pps_cfg_mem u_cfg_mem (
        .i_clk   (i_clk),
        .i_we    (state_reg == PPS_CFG_LOAD && i_flash_valid),
        .i_waddr (addr_reg),
        .i_wdata (i_flash_data),
        .i_raddr (`PPS_CFG_AW'(0)),
        .o_rdata (rd_data)
    );

    // Status flag: released in reset, high in init, low when done
    // Park states hold the flag, so an init cut short by a fast
    // park never tells the host that it may start its traffic
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_host_status_flag_oe <= 1'b0; // [RQ9]
            o_host_status_flag_o  <= 1'b1;
        end else begin
            o_host_status_flag_oe <= 1'b1; // [RQ13]
            if (state_next == PPS_RESET
                    || state_next == PPS_PLL_LOCK
                    || state_next == PPS_CFG_LOAD) begin
                o_host_status_flag_o <= 1'b1; // [RQ13]
            end else if (state_next == PPS_ACTIVE) begin
                o_host_status_flag_o <= 1'b0; // [RQ4]
            end
        end
    end

    // Registered control outputs derived from the next state
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_host_cmd_allow   <= 1'b0;
            o_display_enable   <= 1'b0;
            o_mirror_park_req  <= 1'b0;
            o_mirror_fast_park <= 1'b0;
            o_parked           <= 1'b0;
            o_flash_req        <= 1'b0;
            o_flash_addr       <= '0;
            o_cfg_word0        <= 8'h00;
        end else begin
            o_host_cmd_allow   <= (state_next == PPS_ACTIVE); // [RQ4]
            o_display_enable   <= (state_next == PPS_ACTIVE)
                                  && en_s2_reg; // [RQ1]
            o_mirror_park_req  <= (state_next == PPS_NORMAL_PARK);
            o_mirror_fast_park <= (state_next == PPS_FAST_PARK);
            o_parked           <= (state_next == PPS_PARKED);
            o_flash_req        <= (state_next == PPS_CFG_LOAD);
            o_flash_addr       <= addr_reg;
            o_cfg_word0        <= rd_data;
        end
    end
endmodule : pps_top
`default_nettype wire

// ---- common/pps_cfg.svh ----
// Timing and size constants for the projector power sequencer
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
`define PPS_CLK_MHZ          125
`define PPS_NPARK_MAX_US     20000
`define PPS_NPARK_CYC        ((`PPS_NPARK_MAX_US * `PPS_CLK_MHZ) - 1)
`define PPS_FPARK_MAX_US     32
`define PPS_FPARK_CYC        ((`PPS_FPARK_MAX_US * `PPS_CLK_MHZ) - 1)
`define PPS_PLL_LOCK_CYC     1000
`define PPS_CFG_WORDS        16
`define PPS_CFG_AW           4
`define PPS_CNT_W            22
`endif

// ---- common/pps_pkg.sv ----
// Types for the projector power sequencer
package pps_pkg;
    typedef enum logic [2:0] {
        PPS_RESET,
        PPS_PLL_LOCK,
        PPS_CFG_LOAD,
        PPS_ACTIVE,
        PPS_NORMAL_PARK,
        PPS_FAST_PARK,
        PPS_PARKED
    } pps_state_t;
endpackage : pps_pkg

// ---- rtl/pps_cfg_mem.sv ----
// Small configuration store with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "pps_cfg.svh"
module pps_cfg_mem (
    input  wire logic                    i_clk,
    input  wire logic                    i_we,
    input  wire logic [`PPS_CFG_AW-1:0]  i_waddr,
    input  wire logic [7:0]              i_wdata,
    input  wire logic [`PPS_CFG_AW-1:0]  i_raddr,
    output logic      [7:0]              o_rdata
);
    logic [7:0] mem [0:`PPS_CFG_WORDS-1];

    // Write port and registered read port
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : pps_cfg_mem
`default_nettype wire

// ---- tb/pps_top_asserts.sv ----
// Port checker for the projector power sequencer
`timescale 1ns/1ps
`default_nettype none
module pps_top_asserts (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_projector_enable,
    input wire logic i_fast_park_request_n,
    input wire logic i_pll_locked,
    input wire logic o_flash_req,
    input wire logic o_host_status_flag_o,
    input wire logic o_host_status_flag_oe,
    input wire logic o_host_cmd_allow,
    input wire logic o_display_enable,
    input wire logic o_mirror_park_req,
    input wire logic o_mirror_fast_park,
    input wire logic o_parked
);
    localparam int FP_MIN = 3990;
    localparam int FP_MAX = 4010;
    logic        lock_seen_reg;
    logic [12:0] fp_cnt_reg;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Lock memory and fast park length, both cleared by reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lock_seen_reg <= 1'b0;
            fp_cnt_reg    <= 13'h0;
        end else begin
            lock_seen_reg <= lock_seen_reg | i_pll_locked;
            fp_cnt_reg    <= o_mirror_fast_park ? fp_cnt_reg + 13'h1 : 13'h0;
        end
    end
    sequence s_drive_high;
        o_host_status_flag_oe && o_host_status_flag_o;
    endsequence
    sequence s_drop;
        o_host_cmd_allow && $fell(i_projector_enable) && i_fast_park_request_n;
    endsequence
    property p_release;
        $rose(i_rstn) |-> !o_host_status_flag_oe ##1 s_drive_high;
    endproperty
    property p_done;
        $fell(o_host_status_flag_o) |-> o_host_cmd_allow;
    endproperty
    property p_gate;
        o_host_cmd_allow |-> !o_host_status_flag_o && o_host_status_flag_oe;
    endproperty
    property p_order;
        $rose(o_flash_req) |-> lock_seen_reg;
    endproperty
    property p_npark;
        s_drop |-> ##[1:5] (o_mirror_park_req && !o_display_enable);
    endproperty
    property p_fpark;
        $fell(i_fast_park_request_n) && !o_parked |-> ##[1:5] o_mirror_fast_park;
    endproperty
    property p_fp_time;
        $rose(o_parked) && $past(o_mirror_fast_park)
            |-> fp_cnt_reg > FP_MIN && fp_cnt_reg < FP_MAX;
    endproperty
    property p_hold;
        o_parked |=> o_parked && !o_mirror_fast_park && !o_host_cmd_allow;
    endproperty
    a_release: assert property (p_release)
        else $error("status line not driven high after release");
    a_done: assert property (p_done)
        else $error("init done without host access");
    a_gate: assert property (p_gate)
        else $error("host access before init done");
    a_order: assert property (p_order)
        else $error("flash load before lock");
    a_npark: assert property (p_npark)
        else $error("normal park did not start");
    a_fpark: assert property (p_fpark)
        else $error("fast park did not start");
    a_fp_time: assert property (p_fp_time)
        else $error("fast park length wrong");
    a_hold: assert property (p_hold)
        else $error("parked state left before reset");
endmodule : pps_top_asserts
bind pps_top pps_top_asserts pps_top_asserts_inst (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_projector_enable(i_projector_enable),
    .i_fast_park_request_n(i_fast_park_request_n),
    .i_pll_locked(i_pll_locked), .o_flash_req(o_flash_req),
    .o_host_status_flag_o(o_host_status_flag_o),
    .o_host_status_flag_oe(o_host_status_flag_oe),
    .o_host_cmd_allow(o_host_cmd_allow), .o_display_enable(o_display_enable),
    .o_mirror_park_req(o_mirror_park_req),
    .o_mirror_fast_park(o_mirror_fast_park), .o_parked(o_parked));
`default_nettype wire

// ---- tb/pps_host_model.sv ----
// Clock lock and flash partner of the sequencer
`timescale 1ns/1ps
`default_nettype none
module pps_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_flash_req,
    input  wire logic       i_slow,
    output logic            o_pll_locked,
    output logic            o_flash_valid,
    output logic      [7:0] o_flash_data
);
    logic [4:0] lock_reg;
    logic [3:0] word_reg;
    // Lock comes a while after release, so init waits on it
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lock_reg     <= 5'h0;
            o_pll_locked <= 1'b0;
        end else begin
            lock_reg     <= lock_reg + {4'h0, ~&lock_reg};
            o_pll_locked <= &lock_reg;
        end
    end
    // Words in order; slow mode gaps, idle data toggles
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            word_reg      <= 4'h0;
            o_flash_valid <= 1'b0;
            o_flash_data  <= 8'h00;
        end else if (i_flash_req && !(i_slow && o_flash_valid)) begin
            o_flash_valid <= 1'b1;
            o_flash_data  <= 8'hA0 + {4'h0, word_reg};
            word_reg      <= word_reg + 4'h1;
        end else begin
            o_flash_valid <= 1'b0;
            o_flash_data  <= ~o_flash_data;
        end
    end
endmodule : pps_host_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the projector power sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk, rstn, en, park_n, slow, lock, fvld, freq;
    logic       flag, oe, allow, disp, preq, fpark, parked;
    logic [7:0] fdat, w0;
    logic [3:0] faddr;
    int         mismatches, checks;
    pps_top pps_top_inst (.i_clk(clk), .i_rstn(rstn),
        .i_projector_enable(en), .i_fast_park_request_n(park_n),
        .i_pll_locked(lock), .i_flash_valid(fvld), .i_flash_data(fdat),
        .o_flash_req(freq), .o_flash_addr(faddr),
        .o_host_status_flag_o(flag), .o_host_status_flag_oe(oe),
        .o_host_cmd_allow(allow), .o_display_enable(disp),
        .o_mirror_park_req(preq), .o_mirror_fast_park(fpark),
        .o_parked(parked), .o_cfg_word0(w0));
    pps_host_model pps_host_model_inst (.i_clk(clk), .i_rstn(rstn),
        .i_flash_req(freq), .i_slow(slow), .o_pll_locked(lock),
        .o_flash_valid(fvld), .o_flash_data(fdat));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Outputs settle 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic start(input logic s);
        @(posedge clk);
        slow   <= s;
        rstn   <= 1'b0;
        en     <= 1'b1;
        park_n <= 1'b1;
        cyc(8);
        chk("oe_in_reset", 8'h0, oe);
        @(posedge clk);
        rstn <= 1'b1;
        cyc(3);
        chk("flag_drive", 8'h1, oe & flag);
    endtask : start
    task automatic t_startup(input logic s);
        int n;
        start(s);
        n = 0;
        while (flag !== 1'b0 && n < 3000) begin
            cyc(1);
            n++;
        end
        chk("init_done", 8'h0, flag);
        chk("allow_disp", 8'h1, allow & disp);
        chk("flash_addr", 8'h0F, {4'h0, faddr});
        cyc(3);
        chk("cfg_word0", 8'hA0, w0);
        $display("test startup done");
    endtask : t_startup
    // Normal park overtaken by fast park, then held until reset
    task automatic t_park();
        t_startup(1'b0);
        @(posedge clk);
        en <= 1'b0;
        cyc(6);
        chk("park_req", 8'h1, preq & ~disp & ~allow);
        @(posedge clk);
        park_n <= 1'b0;
        cyc(6);
        chk("fast_first", 8'h1, fpark & ~preq);
        cyc(4004);
        chk("parked", 8'h1, parked & ~fpark);
        @(posedge clk);
        en <= 1'b1;
        cyc(6);
        chk("stay_parked", 8'h1, parked & ~disp);
        $display("test park done");
    endtask : t_park
    task automatic t_fast_init();
        start(1'b1);
        @(posedge clk);
        park_n <= 1'b0;
        cyc(6);
        chk("fast_in_init", 8'h1, fpark & ~freq);
        cyc(4004);
        chk("parked_init", 8'h1, parked & ~allow);
        chk("flag_abort", 8'h1, flag & oe);
        $display("test fast init done");
    endtask : t_fast_init
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        {rstn, en, park_n, slow} = 4'b0010;
        mismatches = 0;
        checks = 0;
        t_startup(1'b1);
        t_park();
        t_fast_init();
        end_of_test();
    end
    // Hang guard, about two and a half times the expected run
    initial begin
        cyc(20000);
        mismatches++;
        $display("ERROR watchdog expected done seen hang");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
